// ==== common/ebus_pkg.sv ====
// shared types and constants for the external bus strobe control
package ebus_pkg;
   // ==========================================================
   // access description
   typedef enum logic [1:0] {SPACE_PROG, SPACE_DATA, SPACE_IO} space_t;
   typedef struct packed {
      space_t space;
      logic write;
      logic dma;
      logic [3:0] wait_states;
   } req_t;
   localparam int REQ_W = $bits(req_t);
   // ==========================================================
   // sequencer states
   typedef enum logic {ST_IDLE, ST_ACCESS} state_t;
   // ==========================================================
   // one driven pin: output value and enable
   typedef struct packed {
      logic o;
      logic oe;
   } pin_t;
   localparam pin_t PIN_RST = 2'b10;
   // ==========================================================
   // wait states from which the ready pin is sampled
   localparam logic [3:0] READY_MIN_WAITS = 4'h2;
   // extension per low ready sample, in cycles
   localparam int EXTEND_CYCLES = 1;
   // ==========================================================
   // synchronised pin inputs: bit positions and values at reset
   localparam int SYNC_W = 8;
   localparam int SYNC_STAGES = 3;
   localparam int IX_FLOAT = 0;
   localparam int IX_CONFIG = 1;
   localparam int IX_READY = 2;
   localparam int IX_PROG_SEL = 3;
   localparam int IX_DATA_SEL = 4;
   localparam int IX_RW = 5;
   localparam int IX_IO_SEL = 6;
   localparam int IX_IO_STROBE = 7;
   localparam logic [SYNC_W-1:0] SYNC_RST = 8'h3b;
   // config pin level that selects external memory mode
   localparam logic MODE_EXTERNAL = 1'b1;
   localparam logic MODE_RST = 1'b1;
endpackage : ebus_pkg

// ==== design/access_buffer.sv ====
// two-entry request buffer with registered output
`timescale 1ns/100ps
module access_buffer #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic out_valid_reg, out_valid_next;
   logic skid_valid_reg, skid_valid_next;
   logic [WIDTH-1:0] out_data_reg, out_data_next;
   logic [WIDTH-1:0] skid_data_reg, skid_data_next;
   logic in_ready_reg;

   // ==========================================================
   // skid pair: second entry catches a word while drain stalls
   always_comb begin
      out_valid_next = out_valid_reg;
      out_data_next = out_data_reg;
      skid_valid_next = skid_valid_reg;
      skid_data_next = skid_data_reg;
      if (out_ready || !out_valid_reg) begin
         if (skid_valid_reg) begin
            out_valid_next = 1'b1;
            out_data_next = skid_data_reg;
            skid_valid_next = 1'b0;
         end else begin
            out_valid_next = in_valid;
            out_data_next = in_data;
         end
      end else if (in_valid && !skid_valid_reg) begin
         skid_valid_next = 1'b1;
         skid_data_next = in_data;
      end
   end

   // registers only
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid_reg <= 1'b0;
         skid_valid_reg <= 1'b0;
         out_data_reg <= '0;
         skid_data_reg <= '0;
         in_ready_reg <= 1'b1;
      end else begin
         out_valid_reg <= out_valid_next;
         skid_valid_reg <= skid_valid_next;
         out_data_reg <= out_data_next;
         skid_data_reg <= skid_data_next;
         in_ready_reg <= !skid_valid_next;
      end
   end

   // full once the skid entry holds a word; kept as a flop of its own
   // so the top-level ready output comes straight from a register
   assign in_ready = in_ready_reg;
   assign out_valid = out_valid_reg;
   assign out_data = out_data_reg;
endmodule : access_buffer

// ==== design/external_bus_strobe_control.sv ====
// external asynchronous bus strobe, select and pin-mux control
`timescale 1ns/100ps
module external_bus_strobe_control (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // core request stream
   input wire logic req_valid,
   output logic req_ready,
   input wire ebus_pkg::req_t req_data,
   // completion
   output logic done_valid,
   output logic done_error,
   // mode and float pins
   input wire logic float_n_in,
   input wire logic port_config_select_in,
   // program select pin, host strobe one in host mode
   input wire logic program_space_select_n_in,
   output ebus_pkg::pin_t program_space_select_n_pin,
   // data select pin, host strobe two in host mode
   input wire logic data_space_select_n_in,
   output ebus_pkg::pin_t data_space_select_n_pin,
   // io select pin, second gp bit 3 in host mode
   input wire logic io_space_select_n_in,
   output ebus_pkg::pin_t io_space_select_n_pin,
   // io strobe pin, first gp bit 3 in host mode
   input wire logic io_strobe_n_in,
   output ebus_pkg::pin_t io_strobe_n_pin,
   // memory strobe pin
   output ebus_pkg::pin_t memory_strobe_n_pin,
   // ready pin, host-port ready output in host mode
   input wire logic ready_in,
   output ebus_pkg::pin_t ready_pin,
   // direction pin, host direction input in host mode
   input wire logic read_write_n_in,
   output ebus_pkg::pin_t read_write_n_pin,
   // host-port side
   input wire logic host_port_ready,
   output logic host_data_strobe_first_n,
   output logic host_data_strobe_second_n,
   output logic host_read_write_n,
   output logic host_port_mode,
   // first subsystem gp bit 3 and timer
   input wire logic first_subsystem_gp_bit3_out,
   input wire logic first_subsystem_gp_bit3_oe,
   input wire logic first_subsystem_timer_out,
   input wire logic first_subsystem_timer_sel,
   output logic first_subsystem_gp_bit3_in,
   // second subsystem gp bit 3 and timer
   input wire logic second_subsystem_gp_bit3_out,
   input wire logic second_subsystem_gp_bit3_oe,
   input wire logic second_subsystem_timer_out,
   input wire logic second_subsystem_timer_sel,
   output logic second_subsystem_gp_bit3_in
);
   // ==========================================================
   // select decode, active low, one bit per space
   function automatic logic [2:0] sel_for(input ebus_pkg::space_t s);
      logic [2:0] r;
      r = 3'h7;
      case (s)
         ebus_pkg::SPACE_PROG: r = 3'h6;
         ebus_pkg::SPACE_DATA: r = 3'h5;
         ebus_pkg::SPACE_IO: r = 3'h3;
         default: r = 3'h7;
      endcase
      return r;
   endfunction : sel_for

   // ==========================================================
   // pin synchronisers
   logic [ebus_pkg::SYNC_W-1:0] pins_raw;
   logic [ebus_pkg::SYNC_W-1:0] s1_reg, s2_reg, s3_reg;
   logic [ebus_pkg::SYNC_W-1:0] filt_reg, filt_next;

   assign pins_raw = {io_strobe_n_in, io_space_select_n_in,
                      read_write_n_in, data_space_select_n_in,
                      program_space_select_n_in, ready_in,
                      port_config_select_in, float_n_in};

   // a bit moves only once stages two and three agree
   always_comb begin
      filt_next = (s2_reg & ~(s2_reg ^ s3_reg)) |
                  (filt_reg & (s2_reg ^ s3_reg));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= ebus_pkg::SYNC_RST;
         s2_reg <= ebus_pkg::SYNC_RST;
         s3_reg <= ebus_pkg::SYNC_RST;
         filt_reg <= ebus_pkg::SYNC_RST;
      end else begin
         s1_reg <= pins_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   logic float_ok, cfg_ext, ready_ok;
   assign float_ok = filt_reg[ebus_pkg::IX_FLOAT];
   assign cfg_ext = filt_reg[ebus_pkg::IX_CONFIG]
                    == ebus_pkg::MODE_EXTERNAL;
   assign ready_ok = filt_reg[ebus_pkg::IX_READY];

   // ==========================================================
   // request buffer
   logic buf_valid, buf_ready;
   ebus_pkg::req_t buf_data;

   access_buffer #(
      .WIDTH(ebus_pkg::REQ_W)
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data(req_data),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_data)
   );

   // ==========================================================
   // access sequencer
   ebus_pkg::state_t state_reg, state_next;
   ebus_pkg::req_t cur_reg, cur_next;
   logic [3:0] cnt_reg, cnt_next;
   logic mode_reg, mode_next;
   logic done_reg, done_next;
   logic err_reg, err_next;
   logic take;

   // new work only when both the pending and the applied mode are external
   assign take = (state_reg == ebus_pkg::ST_IDLE) && buf_valid &&
                 mode_reg == ebus_pkg::MODE_EXTERNAL && cfg_ext;
   assign buf_ready = take;

   always_comb begin
      state_next = state_reg;
      cur_next = cur_reg;
      cnt_next = cnt_reg;
      mode_next = mode_reg;
      done_next = 1'b0;
      err_next = 1'b0;
      case (state_reg)
         ebus_pkg::ST_IDLE: begin
            // mode is applied between accesses only
            mode_next = cfg_ext;
            if (take) begin
               if (buf_data.dma &&
                   buf_data.space == ebus_pkg::SPACE_IO) begin
                  // dma never reaches external io space
                  done_next = 1'b1;
                  err_next = 1'b1;
               end else begin
                  state_next = ebus_pkg::ST_ACCESS;
                  cur_next = buf_data;
                  cnt_next = buf_data.wait_states;
               end
            end
         end
         ebus_pkg::ST_ACCESS: begin
            if (cnt_reg != 4'h0) begin
               cnt_next = cnt_reg - 4'h1;
            end else if (cur_reg.wait_states >=
                         ebus_pkg::READY_MIN_WAITS
                         && !ready_ok) begin
               // hold one more cycle, then look again
               cnt_next = 4'(ebus_pkg::EXTEND_CYCLES - 1);
            end else begin
               state_next = ebus_pkg::ST_IDLE;
               done_next = 1'b1;
            end
         end
         default: state_next = ebus_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ebus_pkg::ST_IDLE;
         cur_reg <= '0;
         cnt_reg <= 4'h0;
         mode_reg <= ebus_pkg::MODE_RST;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cur_reg <= cur_next;
         cnt_reg <= cnt_next;
         mode_reg <= mode_next;
         done_reg <= done_next;
         err_reg <= err_next;
      end
   end

   assign done_valid = done_reg;
   assign done_error = err_reg;

   // ==========================================================
   // pin drive, computed from the next state so pins are flops
   ebus_pkg::pin_t ps_next, ds_next, is_next, ios_next;
   ebus_pkg::pin_t ms_next, rdy_next, rw_next;
   ebus_pkg::pin_t ps_reg, ds_reg, is_reg, ios_reg;
   ebus_pkg::pin_t ms_reg, rdy_reg, rw_reg;
   logic [2:0] sel_n;
   logic act, ext;

   always_comb begin
      act = state_next == ebus_pkg::ST_ACCESS;
      ext = mode_next == ebus_pkg::MODE_EXTERNAL;
      // one space bit at a time
      sel_n = act ? sel_for(cur_next.space) : 3'h7;
      ps_next.o = sel_n[0];
      ds_next.o = sel_n[1];
      is_next.o = sel_n[2];
      ms_next.o = !(act && ext &&
                    cur_next.space != ebus_pkg::SPACE_IO);
      ios_next.o = !(act && !cur_next.dma &&
                     cur_next.space == ebus_pkg::SPACE_IO);
      rw_next.o = !(act && cur_next.write);
      rdy_next.o = host_port_ready;
      ps_next.oe = ext;
      ds_next.oe = ext;
      is_next.oe = ext;
      ios_next.oe = ext;
      ms_next.oe = ext;
      rw_next.oe = ext;
      rdy_next.oe = !ext;
      if (!ext) begin
         // gp bit 3 pins, timer output when selected
         is_next.o = second_subsystem_timer_sel ?
                     second_subsystem_timer_out :
                     second_subsystem_gp_bit3_out;
         is_next.oe = second_subsystem_timer_sel ||
                      second_subsystem_gp_bit3_oe;
         ios_next.o = first_subsystem_timer_sel ?
                      first_subsystem_timer_out :
                      first_subsystem_gp_bit3_out;
         ios_next.oe = first_subsystem_timer_sel ||
                       first_subsystem_gp_bit3_oe;
      end
      if (!float_ok) begin
         // global float wins over every mode
         ps_next.oe = 1'b0;
         ds_next.oe = 1'b0;
         is_next.oe = 1'b0;
         ios_next.oe = 1'b0;
         ms_next.oe = 1'b0;
         rw_next.oe = 1'b0;
         rdy_next.oe = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ps_reg <= ebus_pkg::PIN_RST;
         ds_reg <= ebus_pkg::PIN_RST;
         is_reg <= ebus_pkg::PIN_RST;
         ios_reg <= ebus_pkg::PIN_RST;
         ms_reg <= ebus_pkg::PIN_RST;
         rdy_reg <= ebus_pkg::PIN_RST;
         rw_reg <= ebus_pkg::PIN_RST;
      end else begin
         ps_reg <= ps_next;
         ds_reg <= ds_next;
         is_reg <= is_next;
         ios_reg <= ios_next;
         ms_reg <= ms_next;
         rdy_reg <= rdy_next;
         rw_reg <= rw_next;
      end
   end

   assign program_space_select_n_pin = ps_reg;
   assign data_space_select_n_pin = ds_reg;
   assign io_space_select_n_pin = is_reg;
   assign io_strobe_n_pin = ios_reg;
   assign memory_strobe_n_pin = ms_reg;
   assign ready_pin = rdy_reg;
   assign read_write_n_pin = rw_reg;

   // ==========================================================
   // host-side views of the shared pins, all filtered flops
   assign host_data_strobe_first_n = filt_reg[ebus_pkg::IX_PROG_SEL];
   assign host_data_strobe_second_n = filt_reg[ebus_pkg::IX_DATA_SEL];
   assign host_read_write_n = filt_reg[ebus_pkg::IX_RW];
   assign first_subsystem_gp_bit3_in = filt_reg[ebus_pkg::IX_IO_STROBE];
   assign second_subsystem_gp_bit3_in = filt_reg[ebus_pkg::IX_IO_SEL];
   // inverted copy of the applied mode, kept as its own flop
   logic host_mode_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         host_mode_reg <= 1'b0;
      end else begin
         host_mode_reg <= !mode_next;
      end
   end
   assign host_port_mode = host_mode_reg;

   // ==========================================================
   // checks
   a_prog_select: assert property (@(posedge clk) disable iff (rst)
      state_reg == ebus_pkg::ST_ACCESS &&
      cur_reg.space == ebus_pkg::SPACE_PROG |-> !ps_reg.o)
      else $error("program select not low in program access");
   a_data_select: assert property (@(posedge clk) disable iff (rst)
      state_reg == ebus_pkg::ST_ACCESS &&
      cur_reg.space == ebus_pkg::SPACE_DATA |-> !ds_reg.o)
      else $error("data select not low in data access");
   a_io_select: assert property (@(posedge clk) disable iff (rst)
      state_reg == ebus_pkg::ST_ACCESS &&
      cur_reg.space == ebus_pkg::SPACE_IO |-> !is_reg.o && !ios_reg.o)
      else $error("io select or strobe not low in io access");
   a_float_release: assert property (@(posedge clk) disable iff (rst)
      !float_ok |=> !(ps_reg.oe | ds_reg.oe | is_reg.oe | ios_reg.oe |
                      ms_reg.oe | rw_reg.oe))
      else $error("pin driven while floated");
   a_memory_strobe_n_mode: assert property (@(posedge clk) disable iff (rst)
      !ms_reg.o |-> mode_reg && state_reg == ebus_pkg::ST_ACCESS &&
                   cur_reg.space != ebus_pkg::SPACE_IO)
      else $error("memory strobe outside memory-mode access");
   a_ready_extend: assert property (@(posedge clk) disable iff (rst)
      state_reg == ebus_pkg::ST_ACCESS && cnt_reg == 4'h0 &&
      cur_reg.wait_states >= 4'h2 && !ready_ok
      |=> state_reg == ebus_pkg::ST_ACCESS && !done_reg)
      else $error("access ended with ready low");
   a_ready_ignore: assert property (@(posedge clk) disable iff (rst)
      state_reg == ebus_pkg::ST_ACCESS && cnt_reg == 4'h0 &&
      cur_reg.wait_states < 4'h2 |=> done_reg ##1 (!done_reg || err_reg))
      else $error("short access did not end on time");
   a_rw_write: assert property (@(posedge clk) disable iff (rst)
      !rw_reg.o |-> state_reg == ebus_pkg::ST_ACCESS && cur_reg.write)
      else $error("direction low outside a write");
   a_dma_no_io: assert property (@(posedge clk) disable iff (rst)
      take && buf_data.dma && buf_data.space == ebus_pkg::SPACE_IO
      |=> done_reg && err_reg && state_reg == ebus_pkg::ST_IDLE)
      else $error("dma reached io space");
   a_host_pins: assert property (@(posedge clk) disable iff (rst)
      !mode_reg |-> !ps_reg.oe && !ds_reg.oe && !rw_reg.oe &&
                    rdy_reg.oe == float_ok && $past(float_ok) == float_ok
                    || !mode_reg && float_ok != $past(float_ok))
      else $error("host mode pin roles wrong");
   a_one_select: assert property (@(posedge clk) disable iff (rst)
      $onehot0(~{ps_reg.o, ds_reg.o, is_reg.o}) || !mode_reg)
      else $error("two space selects active");
   a_mode_hold: assert property (@(posedge clk) disable iff (rst)
      state_reg == ebus_pkg::ST_ACCESS |=> $stable(mode_reg))
      else $error("mode changed during access");
endmodule : external_bus_strobe_control

// ==== tb/memory_target_model.sv ====
// behavioural external memory target answering on the ready pin
`timescale 1ns/100ps
module memory_target_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // strobe levels seen on the bus wires
   input wire logic memory_strobe_n,
   input wire logic io_strobe_n,
   // cycles the target holds off, zero means always ready
   input wire logic [7:0] hold_cycles,
   // ready level driven back
   output logic ready_out
);
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic active;
   // count strobe cycles of the current access, saturating
   assign active = !memory_strobe_n || !io_strobe_n;
   always_comb begin
      count_next = 8'h00;
      if (active) begin
         count_next = (count_reg == 8'hff) ? count_reg : count_reg + 8'h01;
      end
   end
   always_ff @(posedge clk) begin
      count_reg <= rst ? 8'h00 : count_next;
   end
   // slow target stays low between accesses so a late answer is visible
   assign ready_out = (hold_cycles == 8'h00) ||
                      (active && count_reg >= hold_cycles);
endmodule : memory_target_model

// ==== tb/tb.sv ====
// self-checking bench for the external bus strobe control
`timescale 1ns/100ps
module tb;
   // ==========================================================
   // stimulus and observed signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   ebus_pkg::req_t req_data = '0;
   logic float_n = 1'b1;
   logic cfg = 1'b1;
   logic host_ds1 = 1'b1;
   logic host_ds2 = 1'b1;
   logic host_rw = 1'b1;
   logic hp_ready = 1'b0;
   logic [3:0] gp_a = 4'h0; // out, oe, timer out, timer select
   logic [3:0] gp_b = 4'h0;
   logic [7:0] hold = 8'h00;
   logic req_ready, done_valid, done_error, hp_mode;
   logic host_data_strobe_first, host_data_strobe_second, hrw, gp_a_in, gp_b_in, model_rdy;
   ebus_pkg::pin_t ps_p, ds_p, is_p, ios_p, ms_p, rdy_p, rw_p;
   logic ps_w, ds_w, is_w, ios_w, ms_w, rdy_w, rw_w;
   int n_errors = 0;
   int compares = 0;
   always #10 clk = ~clk;
   // wire levels: released io select, io strobe and memory strobe lines are pulled high; other released pins take the host or model level
   assign ps_w = ps_p.oe ? ps_p.o : host_ds1;
   assign ds_w = ds_p.oe ? ds_p.o : host_ds2;
   assign is_w = is_p.oe ? is_p.o : 1'b1;
   assign ios_w = ios_p.oe ? ios_p.o : 1'b1;
   assign ms_w = ms_p.oe ? ms_p.o : 1'b1;
   assign rdy_w = rdy_p.oe ? rdy_p.o : model_rdy;
   assign rw_w = rw_p.oe ? rw_p.o : host_rw;
   external_bus_strobe_control u_dut (
      .clk(clk), .rst(rst),
      .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
      .done_valid(done_valid), .done_error(done_error),
      .float_n_in(float_n), .port_config_select_in(cfg),
      .program_space_select_n_in(ps_w), .program_space_select_n_pin(ps_p),
      .data_space_select_n_in(ds_w), .data_space_select_n_pin(ds_p),
      .io_space_select_n_in(is_w), .io_space_select_n_pin(is_p),
      .io_strobe_n_in(ios_w), .io_strobe_n_pin(ios_p),
      .memory_strobe_n_pin(ms_p),
      .ready_in(rdy_w), .ready_pin(rdy_p),
      .read_write_n_in(rw_w), .read_write_n_pin(rw_p),
      .host_port_ready(hp_ready),
      .host_data_strobe_first_n(host_data_strobe_first), .host_data_strobe_second_n(host_data_strobe_second),
      .host_read_write_n(hrw), .host_port_mode(hp_mode),
      .first_subsystem_gp_bit3_out(gp_a[3]),
      .first_subsystem_gp_bit3_oe(gp_a[2]),
      .first_subsystem_timer_out(gp_a[1]),
      .first_subsystem_timer_sel(gp_a[0]),
      .first_subsystem_gp_bit3_in(gp_a_in),
      .second_subsystem_gp_bit3_out(gp_b[3]),
      .second_subsystem_gp_bit3_oe(gp_b[2]),
      .second_subsystem_timer_out(gp_b[1]),
      .second_subsystem_timer_sel(gp_b[0]),
      .second_subsystem_gp_bit3_in(gp_b_in)
   );
   memory_target_model u_mem (
      .clk(clk), .rst(rst), .memory_strobe_n(ms_w), .io_strobe_n(ios_w),
      .hold_cycles(hold), .ready_out(model_rdy)
   );
   // ==========================================================
   // shared tasks
   task end_sim;
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // offer one request and hold it until the edge where the buffer accepts it
   task send(input ebus_pkg::space_t sp, input logic wr, input logic dm,
             input logic [3:0] ws);
      int n;
      logic rdy;
      @(posedge clk);
      req_valid <= 1'b1;
      req_data <= '{space: sp, write: wr, dma: dm, wait_states: ws};
      n = 0;
      do begin
         #1 rdy = req_ready;
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 40);
      req_valid <= 1'b0;
      if (rdy !== 1'b1) begin
         n_errors++;
         end_sim();
      end
   endtask : send
   // run one access, watching the pins until three cycles past done
   task access(input ebus_pkg::space_t sp, input logic wr, input logic dm,
               input logic [3:0] ws, input int lo, input int hi,
               input logic err);
      int len, post, n;
      logic [2:0] act, exp_act;
      send(sp, wr, dm, ws);
      len = 0;
      post = -1;
      // only dma to io space is refused; dma to memory runs normally
      exp_act = (dm && sp == ebus_pkg::SPACE_IO) ? 3'b000 : (3'b001 << sp);
      for (n = 0; n < 90 && post < 3; n++) begin
         @(posedge clk);
         #1 act = ~{is_p.o, ds_p.o, ps_p.o};
         chk(act & ~exp_act, 8'h00);
         if (act != 3'b000) begin
            len++;
            chk(ms_p.o, sp == ebus_pkg::SPACE_IO);
            chk(ios_p.o, sp != ebus_pkg::SPACE_IO);
            chk(rw_p.o, !wr);
         end else chk(rw_p.o, 1'b1);
         if (done_valid === 1'b1) begin
            chk(done_error, err);
            post = 0;
         end else if (post >= 0) post++;
      end
      if (post < 3) begin
         n_errors++;
         end_sim();
      end else chk(len >= lo && len <= hi, 1'b1);
   endtask : access
   // ==========================================================
   // scenarios
   task t_spaces;
      access(ebus_pkg::SPACE_PROG, 1'b0, 1'b0, 4'h0, 1, 1, 1'b0);
      access(ebus_pkg::SPACE_DATA, 1'b1, 1'b0, 4'h1, 2, 2, 1'b0);
      access(ebus_pkg::SPACE_IO, 1'b0, 1'b0, 4'h2, 3, 3, 1'b0);
      access(ebus_pkg::SPACE_IO, 1'b1, 1'b0, 4'h3, 4, 4, 1'b0);
      access(ebus_pkg::SPACE_PROG, 1'b1, 1'b0, 4'hf, 16, 16, 1'b0);
   endtask : t_spaces
   task t_ready;
      @(posedge clk);
      hold <= 8'h06;
      access(ebus_pkg::SPACE_DATA, 1'b0, 1'b0, 4'h1, 2, 2, 1'b0);
      access(ebus_pkg::SPACE_PROG, 1'b0, 1'b0, 4'h2, 7, 14, 1'b0);
      @(posedge clk);
      hold <= 8'h00;
   endtask : t_ready
   task t_dma;
      access(ebus_pkg::SPACE_IO, 1'b0, 1'b1, 4'h0, 0, 0, 1'b1);
      access(ebus_pkg::SPACE_DATA, 1'b0, 1'b1, 4'h0, 1, 1, 1'b0);
   endtask : t_dma
   task t_float;
      @(posedge clk);
      float_n <= 1'b0;
      repeat (8) @(posedge clk);
      #1 chk({ps_p.oe, ds_p.oe, is_p.oe, ios_p.oe, ms_p.oe, rw_p.oe},
             8'h00);
      @(posedge clk);
      float_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : t_float
   // host mode: pins change roles and the buffer fills without draining
   task t_host;
      int n, dones;
      @(posedge clk);
      cfg <= 1'b0;
      hp_ready <= 1'b1;
      host_ds1 <= 1'b0;
      host_rw <= 1'b0;
      gp_b <= 4'h4;
      gp_a <= 4'h1;
      // released pins reach the host views through the filter only
      // after the mode flop switches, so allow both delays
      repeat (12) @(posedge clk);
      #1 chk(hp_mode, 1'b1);
      chk({ps_p.oe, ds_p.oe, rw_p.oe}, 8'h00);
      chk(rdy_p, 8'h03);
      chk({host_data_strobe_first, host_data_strobe_second, hrw}, 8'h02);
      chk({is_p, gp_b_in}, 8'h02);
      chk({ios_p, gp_a_in}, 8'h02);
      send(ebus_pkg::SPACE_PROG, 1'b0, 1'b0, 4'h0);
      send(ebus_pkg::SPACE_DATA, 1'b1, 1'b0, 4'h0);
      repeat (6) @(posedge clk);
      #1 chk({req_ready, ms_p.o, done_valid}, 8'h02);
      @(posedge clk);
      cfg <= 1'b1;
      host_ds1 <= 1'b1;
      host_rw <= 1'b1;
      dones = 0;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         #1 if (done_valid === 1'b1) dones++;
      end
      chk(dones, 8'h02);
      chk(hp_mode, 1'b0);
   endtask : t_host
   // ==========================================================
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_spaces();
      t_ready();
      t_dma();
      t_float();
      t_host();
      access(ebus_pkg::SPACE_IO, 1'b1, 1'b0, 4'h0, 1, 1, 1'b0);
      end_sim();
   end
endmodule : tb
